// file: dtc_pkg.sv
/*
 * Constants, register map and mode type for the dual timer/counter.
 * Assumes one 200 MHz core clock that doubles as the oscillator.
 */
package dtc_pkg;
	// ------------------------------------------------------------
	// Machine cycle timing
	// ------------------------------------------------------------
	localparam int unsigned OSC_PER_MCYCLE = 12;             // Oscillator periods per cycle
	localparam logic [3:0]  PH_LAST        = 4'(OSC_PER_MCYCLE - 1);
	localparam logic [3:0]  PH_S3P1        = 4'h4;           // Count update phase
	localparam logic [3:0]  PH_S5P2        = 4'h9;           // Count pin sample phase

	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam int unsigned ADDR_W       = 8;
	localparam logic [7:0]  OFF_CTRL     = 8'h00;            // timer_control_reg
	localparam logic [7:0]  OFF_MODE     = 8'h04;            // timer_mode_reg
	localparam logic [7:0]  OFF_CL0      = 8'h08;            // count_low_0
	localparam logic [7:0]  OFF_CH0      = 8'h0c;            // count_high_0
	localparam logic [7:0]  OFF_CL1      = 8'h10;            // count_low_1
	localparam logic [7:0]  OFF_CH1      = 8'h14;            // count_high_1
	localparam logic [7:0]  OFF_IRQ_ST   = 8'h18;            // Sticky status, write 1 clears
	localparam logic [7:0]  OFF_IRQ_MASK = 8'h1c;            // Interrupt mask
	localparam logic [7:0]  OFF_ACK      = 8'h20;            // Vector acknowledge strobes

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int unsigned CTL_OF1   = 7;
	localparam int unsigned CTL_RUN1  = 6;
	localparam int unsigned CTL_OF0   = 5;
	localparam int unsigned CTL_RUN0  = 4;
	localparam int unsigned CTL_EDGE1 = 3;
	localparam int unsigned CTL_TYPE1 = 2;
	localparam int unsigned CTL_EDGE0 = 1;
	localparam int unsigned CTL_TYPE0 = 0;
	localparam int unsigned MOD_GATE1 = 7;
	localparam int unsigned MOD_CT1   = 6;
	localparam int unsigned MOD_M1_LO = 4;
	localparam int unsigned MOD_GATE0 = 3;
	localparam int unsigned MOD_CT0   = 2;
	localparam int unsigned MOD_M0_LO = 0;
	localparam int unsigned EV_OF0    = 0;                   // Status, mask and ack layout
	localparam int unsigned EV_OF1    = 1;
	localparam int unsigned EV_EDGE0  = 2;
	localparam int unsigned EV_EDGE1  = 3;
	localparam int unsigned EV_W      = 4;

	// ------------------------------------------------------------
	// Reset values and bus answers
	// ------------------------------------------------------------
	localparam logic [7:0]      CTRL_RST = 8'h00;
	localparam logic [7:0]      MODE_RST = 8'h00;
	localparam logic [7:0]      CNT_RST  = 8'h00;
	localparam logic [EV_W-1:0] MASK_RST = 4'h0;
	localparam logic [1:0]      RESP_OK  = 2'h0;
	localparam logic [1:0]      RESP_ERR = 2'h2;

	// Operating modes
	typedef enum logic [1:0] {
		MODE_13BIT,
		MODE_16BIT,
		MODE_RELOAD8,
		MODE_SPLIT
	} dtc_mode_t;
endpackage

// file: dtc_sync.sv
/*
 * Two flip-flop synchroniser for a group of pin levels.
 * Assumes each bit is an independent level; no bus coherence.
 */
`timescale 1ns/1ps
module dtc_sync #(
	parameter int unsigned W = 4
) (
	input  wire logic         mclk,
	input  wire logic         rst,
	input  wire logic [W-1:0] pin_in,
	output logic      [W-1:0] pin_sync
);
	logic [W-1:0] meta_q;                                    // First stage, read by stage two only

	// ------------------------------------------------------------
	// Two stages
	// ------------------------------------------------------------
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			meta_q   <= '0;
			pin_sync <= '0;
		end else begin
			meta_q   <= pin_in;
			pin_sync <= meta_q;
		end
	end
endmodule

// file: dtc_phase.sv
/*
 * Machine cycle sequencer: twelve oscillator phases per cycle.
 * Assumes mclk is the oscillator; strobes are one-cycle enables.
 */
`timescale 1ns/1ps
module dtc_phase
	import dtc_pkg::*;
(
	input  wire logic mclk,
	input  wire logic rst,
	output logic      tick_s3p1,
	output logic      tick_s5p2
);
	logic [3:0] ph_q;                                        // Current phase, 0 is S1P1

	// ------------------------------------------------------------
	// Phase counter
	// ------------------------------------------------------------
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ph_q <= 4'h0;
		end else if (ph_q == PH_LAST) begin
			ph_q <= 4'h0;
		end else begin
			ph_q <= ph_q + 4'h1;
		end
	end

	// Strobes decoded straight from the counter flop
	assign tick_s3p1 = (ph_q == PH_S3P1);
	assign tick_s5p2 = (ph_q == PH_S5P2);
endmodule

// file: dtc_top.sv
/*
 * Dual 16-bit timer/counter with an AXI4-Lite register slave.
 * Assumes pins are asynchronous and one AXI master at a time.
 */
// How it works
// - Timer function counts once per machine cycle
// - Count pin sampled at S5P2, falling detected
// - Counted value appears at next S3P1
// - Edge takes two cycles, max rate halved
// - Select bit and two-bit mode per timer
// - Mode 0 counts thirteen bits, top three held
// - Rollover to zero sets overflow flag
// - Count needs run and gate-or-pin high
// - Run bit never clears the count
// - Gate bits at mode bits 7 and 3
// - Mode 1 is full sixteen bits
// - Mode 2 reloads low byte from high
// - Timer 1 in mode 3 holds count
// - Split mode: high byte uses timer 1 controls
// - Timer 1 still overflows during split mode
// - Overflow flags set by hardware, cleared by ack/write
// - Edge flags set on edge, type bits choose
`timescale 1ns/1ps
module dtc_top
	import dtc_pkg::*;
(
	input  wire logic              mclk,
	input  wire logic              rst,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              count_input_0,
	input  wire logic              count_input_1,
	input  wire logic              ext_irq_pin_0,
	input  wire logic              ext_irq_pin_1,
	output logic                   overflow_tick_1,
	output logic                   irq
);
	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic              tick_s3p1, tick_s5p2;                 // Machine cycle strobes
	logic [3:0]        pins_s;                               // Synced cnt1,cnt0,ext_irq_pin_1,ext_irq_pin_0
	logic [ADDR_W-1:0] awaddr_q;                             // Held write address
	logic [7:0]        wbyte_q;                              // Held write data, low lane
	logic              wlane_q;                              // Low lane enabled
	logic              aw_got_q, w_got_q;                    // Channel halves taken
	logic              do_wr, wr_lane;                       // Write commits this cycle
	logic [7:0]        ctrl_q, ctrl_d;                       // timer_control_reg
	logic [7:0]        mode_q;                               // timer_mode_reg
	logic [7:0]        l0_q, h0_q, l1_q, h1_q;               // Count bytes
	logic [EV_W-1:0]   st_q, mask_q, ev;                     // Interrupt status and mask
	logic [1:0]        samp_q, fall_q;                       // Count pin samples, edges
	logic [1:0]        intp_q;                               // Previous int pin levels
	logic [1:0]        int_fall;                             // Int pin falling edges
	dtc_mode_t         m0, m1;                               // Decoded modes
	logic              en0, en1, inc0, inc1, inc_h0;         // Count enables
	logic [16:0]       step0, step1;                         // {carry, high, low}
	logic              of0_set, of1_set, ovf1_raw;           // Overflow events
	logic [7:0]        rd_byte;                              // Read mux

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// One count step for modes 0 to 3; split mode counts the low byte only
	function automatic logic [16:0] dtc_step(input dtc_mode_t m, input logic [7:0] hi,
	                                         input logic [7:0] lo);
		logic [8:0] l9;
		logic [5:0] l6;
		logic [8:0] h9;
		l9       = {1'b0, lo} + 9'h001;
		l6       = {1'b0, lo[4:0]} + 6'h01;
		h9       = 9'h000;
		dtc_step = {1'b0, hi, lo};
		unique case (m)
			MODE_13BIT: begin                                // Top three low bits held
				h9       = {1'b0, hi} + {8'h00, l6[5]};
				dtc_step = {h9[8], h9[7:0], lo[7:5], l6[4:0]};
			end
			MODE_16BIT: begin                                // Full width carry
				h9       = {1'b0, hi} + {8'h00, l9[8]};
				dtc_step = {h9[8], h9[7:0], l9[7:0]};
			end
			MODE_RELOAD8: begin                              // Reload, high kept
				dtc_step = {l9[8], hi, (l9[8] ? hi : l9[7:0])};
			end
			MODE_SPLIT: begin
				dtc_step = {l9[8], hi, l9[7:0]};
			end
		endcase
	endfunction

	// Offsets that answer OKAY; anything else gets SLVERR
	function automatic logic dtc_mapped(input logic [ADDR_W-1:0] a);
		dtc_mapped = (a == OFF_CTRL) || (a == OFF_MODE) || (a == OFF_CL0) ||
		             (a == OFF_CH0) || (a == OFF_CL1) || (a == OFF_CH1) ||
		             (a == OFF_IRQ_ST) || (a == OFF_IRQ_MASK) || (a == OFF_ACK);
	endfunction

	// ------------------------------------------------------------
	// Sequencer and pin synchronisers
	// ------------------------------------------------------------
	dtc_phase u_phase (
		.mclk      (mclk),
		.rst       (rst),
		.tick_s3p1 (tick_s3p1),
		.tick_s5p2 (tick_s5p2)
	);

	dtc_sync #(.W(4)) u_sync (
		.mclk     (mclk),
		.rst      (rst),
		.pin_in   ({count_input_1, count_input_0, ext_irq_pin_1, ext_irq_pin_0}),
		.pin_sync (pins_s)
	);

	// ------------------------------------------------------------
	// AXI4-Lite write channel
	// ------------------------------------------------------------
	assign s_axi_awready = !aw_got_q;
	assign s_axi_wready  = !w_got_q;
	assign do_wr         = aw_got_q && w_got_q && !s_axi_bvalid;
	assign wr_lane       = do_wr && wlane_q;

	// Address and data may arrive in either order; both held until commit
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			aw_got_q <= 1'b0;
			w_got_q  <= 1'b0;
			awaddr_q <= '0;
			wbyte_q  <= 8'h00;
			wlane_q  <= 1'b0;
		end else begin
			if (s_axi_awvalid && !aw_got_q) begin
				aw_got_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end else if (do_wr) begin
				aw_got_q <= 1'b0;
			end
			if (s_axi_wvalid && !w_got_q) begin
				w_got_q <= 1'b1;
				wbyte_q <= s_axi_wdata[7:0];
				wlane_q <= s_axi_wstrb[0];
			end else if (do_wr) begin
				w_got_q <= 1'b0;
			end
		end
	end

	// Response follows the commit and waits for bready
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OK;
		end else if (do_wr) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= dtc_mapped(awaddr_q) ? RESP_OK : RESP_ERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// AXI4-Lite read channel
	// ------------------------------------------------------------
	assign s_axi_arready = !s_axi_rvalid;

	// Read mux; flags read live, counts include held mode-0 bits
	always_comb begin
		rd_byte = 8'h00;
		unique case (s_axi_araddr)
			OFF_CTRL:     rd_byte = ctrl_q;
			OFF_MODE:     rd_byte = mode_q;
			OFF_CL0:      rd_byte = l0_q;
			OFF_CH0:      rd_byte = h0_q;
			OFF_CL1:      rd_byte = l1_q;
			OFF_CH1:      rd_byte = h1_q;
			OFF_IRQ_ST:   rd_byte = {4'h0, st_q};
			OFF_IRQ_MASK: rd_byte = {4'h0, mask_q};
			default:      rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= RESP_OK;
		end else if (s_axi_arvalid && !s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= {24'h00_0000, rd_byte};
			s_axi_rresp  <= dtc_mapped(s_axi_araddr) ? RESP_OK : RESP_ERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Pin sampling
	// ------------------------------------------------------------
	// Count pins sampled once per cycle; a fall stays flagged for one cycle
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			samp_q <= 2'h0;
			fall_q <= 2'h0;
		end else if (tick_s5p2) begin
			samp_q <= pins_s[3:2];
			fall_q <= samp_q & ~pins_s[3:2];
		end
	end

	// External interrupt pin edge detector, on synced levels
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			intp_q <= 2'h0;                                  // Same as synchroniser reset: no false fall
		end else begin
			intp_q <= pins_s[1:0];
		end
	end
	assign int_fall = intp_q & ~pins_s[1:0];

	// ------------------------------------------------------------
	// Count enables
	// ------------------------------------------------------------
	assign m0 = dtc_mode_t'(mode_q[MOD_M0_LO +: 2]);
	assign m1 = dtc_mode_t'(mode_q[MOD_M1_LO +: 2]);

	// Run and gate-or-pin; separate gate bits per timer
	assign en0 = ctrl_q[CTL_RUN0] && (!mode_q[MOD_GATE0] || pins_s[0]);
	// Split mode lends run1 to the high byte; timer 1 then runs unless parked
	assign en1 = (m0 == MODE_SPLIT || ctrl_q[CTL_RUN1] && (!mode_q[MOD_GATE1] || pins_s[1])) &&
	             (m1 != MODE_SPLIT);                         // Mode 3 stops timer 1

	// Machine cycles or pin falls, both landing on S3P1
	assign inc0   = tick_s3p1 && en0 && (!mode_q[MOD_CT0] || fall_q[0]);
	assign inc1   = tick_s3p1 && en1 && (!mode_q[MOD_CT1] || fall_q[1]);
	assign inc_h0 = tick_s3p1 && ctrl_q[CTL_RUN1] && (m0 == MODE_SPLIT);

	assign step0 = dtc_step(m0, h0_q, l0_q);
	assign step1 = dtc_step(m1, h1_q, l1_q);

	// Overflow events; split mode hands timer 1's flag to the high byte
	assign ovf1_raw = inc1 && step1[16];
	assign of0_set  = inc0 && step0[16];
	assign of1_set  = (m0 == MODE_SPLIT) ? (inc_h0 && (h0_q == 8'hff)) : ovf1_raw;

	// ------------------------------------------------------------
	// Count registers
	// ------------------------------------------------------------
	// Timer 0; a bus write wins over a same-cycle step
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			l0_q <= CNT_RST;
			h0_q <= CNT_RST;
		end else begin
			if (wr_lane && awaddr_q == OFF_CL0) begin
				l0_q <= wbyte_q;
			end else if (inc0) begin
				l0_q <= step0[7:0];
			end
			if (wr_lane && awaddr_q == OFF_CH0) begin
				h0_q <= wbyte_q;
			end else if (m0 == MODE_SPLIT) begin
				if (inc_h0) begin
					h0_q <= h0_q + 8'h01;
				end
			end else if (inc0) begin
				h0_q <= step0[15:8];
			end
		end
	end

	// Timer 1; run only gates, so held count resumes
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			l1_q <= CNT_RST;
			h1_q <= CNT_RST;
		end else begin
			if (wr_lane && awaddr_q == OFF_CL1) begin
				l1_q <= wbyte_q;
			end else if (inc1) begin
				l1_q <= step1[7:0];
			end
			if (wr_lane && awaddr_q == OFF_CH1) begin
				h1_q <= wbyte_q;
			end else if (inc1) begin
				h1_q <= step1[15:8];
			end
		end
	end

	// Overflow strobe out, kept even when the flag belongs to timer 0
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			overflow_tick_1 <= 1'b0;
		end else begin
			overflow_tick_1 <= ovf1_raw;
		end
	end

	// ------------------------------------------------------------
	// Control and mode registers
	// ------------------------------------------------------------
	// Write, then acks, then level tracking, then hardware sets last
	always_comb begin
		ctrl_d = ctrl_q;
		if (wr_lane && awaddr_q == OFF_CTRL) begin
			ctrl_d = wbyte_q;                                // Zero clears a flag
		end
		if (wr_lane && awaddr_q == OFF_ACK) begin
			ctrl_d[CTL_OF0]   = ctrl_d[CTL_OF0] & ~wbyte_q[EV_OF0];
			ctrl_d[CTL_OF1]   = ctrl_d[CTL_OF1] & ~wbyte_q[EV_OF1];
			ctrl_d[CTL_EDGE0] = ctrl_d[CTL_EDGE0] & ~wbyte_q[EV_EDGE0];
			ctrl_d[CTL_EDGE1] = ctrl_d[CTL_EDGE1] & ~wbyte_q[EV_EDGE1];
		end
		// Level triggered: flag follows the low pin
		if (!ctrl_q[CTL_TYPE0]) begin
			ctrl_d[CTL_EDGE0] = !pins_s[0];
		end
		if (!ctrl_q[CTL_TYPE1]) begin
			ctrl_d[CTL_EDGE1] = !pins_s[1];
		end
		// Hardware set beats any clear in the same cycle
		if (of0_set) begin
			ctrl_d[CTL_OF0] = 1'b1;
		end
		if (of1_set) begin
			ctrl_d[CTL_OF1] = 1'b1;
		end
		if (ctrl_q[CTL_TYPE0] && int_fall[0]) begin
			ctrl_d[CTL_EDGE0] = 1'b1;
		end
		if (ctrl_q[CTL_TYPE1] && int_fall[1]) begin
			ctrl_d[CTL_EDGE1] = 1'b1;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ctrl_q <= CTRL_RST;
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	// Mode register: gate, select and mode for each timer
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			mode_q <= MODE_RST;
		end else if (wr_lane && awaddr_q == OFF_MODE) begin
			mode_q <= wbyte_q;
		end
	end

	// ------------------------------------------------------------
	// Interrupt status, mask and output
	// ------------------------------------------------------------
	// Status events; a held low level keeps re-setting its bit
	assign ev = {ctrl_d[CTL_EDGE1] && !ctrl_q[CTL_EDGE1] || !ctrl_q[CTL_TYPE1] && !pins_s[1],
	             ctrl_d[CTL_EDGE0] && !ctrl_q[CTL_EDGE0] || !ctrl_q[CTL_TYPE0] && !pins_s[0],
	             of1_set, of0_set};

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			st_q   <= '0;
			mask_q <= MASK_RST;
			irq    <= 1'b0;
		end else begin
			if (wr_lane && awaddr_q == OFF_IRQ_ST) begin
				st_q <= (st_q & ~wbyte_q[EV_W-1:0]) | ev;   // Set wins over clear
			end else begin
				st_q <= st_q | ev;
			end
			if (wr_lane && awaddr_q == OFF_IRQ_MASK) begin
				mask_q <= wbyte_q[EV_W-1:0];
			end
			irq <= |(st_q & mask_q);
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);

	logic no_cnt_wr;                                         // No bus write commits this cycle, to any register
	assign no_cnt_wr = !wr_lane;

	a_cycle_rate: assert property (
		tick_s3p1 |=> !tick_s3p1 [*8] ##1 !tick_s3p1 [*3] ##1 tick_s3p1)
		else $error("machine cycle strobe spacing wrong");
	a_timer_inc: assert property (
		tick_s3p1 && en0 && !mode_q[MOD_CT0] && m0 == MODE_16BIT
		&& no_cnt_wr |=> {h0_q, l0_q} == 16'($past({h0_q, l0_q}) + 16'h0001))
		else $error("mode 1 timer did not step by one");
	a_fall_sample: assert property ($rose(fall_q[0]) |-> $past(tick_s5p2))
		else $error("count pin edge seen outside sample phase");
	a_gate_hold: assert property (!ctrl_q[CTL_RUN0] && no_cnt_wr |=> $stable(l0_q))
		else $error("timer 0 low byte moved while stopped");
	a_reload_8: assert property (
		inc1 && m1 == MODE_RELOAD8 && m0 != MODE_SPLIT && l1_q == 8'hff && no_cnt_wr
		|=> l1_q == $past(h1_q) && ctrl_q[CTL_OF1] && $stable(h1_q))
		else $error("mode 2 reload or flag missing");
	a_mode0_wrap: assert property (
		inc0 && m0 == MODE_13BIT && h0_q == 8'hff
		&& l0_q[4:0] == 5'h1f && no_cnt_wr |=> h0_q == 8'h00 && ctrl_q[CTL_OF0])
		else $error("13-bit rollover wrong");
	a_t1_split_hold: assert property (
		m1 == MODE_SPLIT && no_cnt_wr |=> $stable({h1_q, l1_q}))
		else $error("timer 1 moved in mode 3");
	a_split_high: assert property (
		tick_s3p1 && m0 == MODE_SPLIT && ctrl_q[CTL_RUN1]
		&& no_cnt_wr |=> h0_q == 8'($past(h0_q) + 8'h01))
		else $error("split high byte did not count");
	a_run_keeps: assert property (
		$rose(ctrl_q[CTL_RUN1]) && no_cnt_wr |-> {h1_q, l1_q} == $past({h1_q, l1_q}))
		else $error("run bit cleared timer 1");
	a_write_wins: assert property (
		wr_lane && awaddr_q == OFF_CL1 |=> l1_q == $past(wbyte_q))
		else $error("count write lost to increment");
endmodule

// file: dtc_pins.sv
/*
 * Partner model of the external count pin.
 * Assumes the bench starts and stops pulsing through pulse_en.
 */
`timescale 1ns/1ps
module dtc_pins (
	input  wire logic mclk,
	input  wire logic pulse_en,
	output logic      cnt_pin,
	output int        falls
);
	int ph; // Position within one level
	initial begin
		cnt_pin = 1'b1;
		falls = 0;
		ph = 0;
	end
	// Each level stands 24 mclk, more than one machine cycle
	// Stopping always parks the pin high, so no fall is left half counted
	always @(posedge mclk) begin
		ph <= (ph == 23) ? 0 : ph + 1;
		if (ph == 23 && (pulse_en || !cnt_pin)) begin
			cnt_pin <= ~cnt_pin;
			if (cnt_pin)
				falls <= falls + 1;
		end
	end
endmodule

// file: dtc_top_tb.sv
/*
 * Self-checking bench for the dual timer/counter.
 * Assumes the register map and bus latencies of the design note.
 */
`timescale 1ns/1ps
module dtc_top_tb;
	import dtc_pkg::*;
	logic        mclk, rst, awvalid, wvalid, bready, arvalid, rready, pulse_en, gin;
	logic        awready, wready, bvalid, arready, rvalid, cin, tick1, irq;
	logic [7:0]  awaddr, araddr, k;
	logic [31:0] wdata, rdata, v, lv;
	logic [1:0]  bresp, rresp, r;
	int          falls, num_errors, checks, cyc, ticks, seed, t0, f0, cnt, i;
	logic [7:0]  offs [6] = '{OFF_CTRL, OFF_MODE, OFF_CL0, OFF_CH0, OFF_CL1, OFF_CH1};
	logic [7:0]  lows [3] = '{8'hff, 8'h1f, 8'h1f};
	logic [31:0] mods [3] = '{32'h1, 32'h0, 32'h1};
	logic [31:0] ctls [3] = '{32'h30, 32'h30, 32'h10};

	dtc_top dtc_top_i (.mclk(mclk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.count_input_0(cin), .count_input_1(cin), .ext_irq_pin_0(gin), .ext_irq_pin_1(gin),
		.overflow_tick_1(tick1), .irq(irq));
	dtc_pins dtc_pins_i (.mclk(mclk), .pulse_en(pulse_en), .cnt_pin(cin), .falls(falls));

	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	// Hang guard and baud tick counter
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (tick1 === 1'b1)
			ticks <= ticks + 1;
		if (cyc == 20000) begin
			num_errors = num_errors + 1;
			tally_and_finish();
		end
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Write: both halves offered together, each dropped once taken
	task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rr);
		logic da, dw;
		da = 0;
		dw = 0;
		@(posedge mclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(da && dw)) begin
			@(negedge mclk);
			da = da | (awready === 1'b1);
			dw = dw | (wready === 1'b1);
			@(posedge mclk);
			if (da)
				awvalid <= 1'b0;
			if (dw)
				wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1)
			@(negedge mclk);
		rr = bresp;
		@(posedge mclk);
		bready <= 1'b0;
	endtask
	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rr);
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		@(negedge mclk);
		while (arready !== 1'b1)
			@(negedge mclk);
		@(posedge mclk);
		arvalid <= 1'b0;
		@(negedge mclk);
		while (rvalid !== 1'b1)
			@(negedge mclk);
		d = rdata;
		rr = rresp;
		@(posedge mclk);
		rready <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		axw(a, d, r);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
		axr(a, v, r);
		check(what, v, exp);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{awvalid, wvalid, bready, arvalid, rready, pulse_en} = '0;
		{awaddr, araddr, wdata, num_errors, checks, cyc, ticks} = '0;
		gin = 1'b1;
		seed = 63;
		rst = 1'b1;
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		repeat (8) @(posedge mclk);
		wr(OFF_IRQ_ST, 32'hf);
		foreach (offs[n])
			rd(offs[n], 32'h0, "reset value");
		axr(8'h24, v, r);
		check("unmapped read", 32'(r), 32'(RESP_ERR));
		axw(8'h28, 32'h1, r);
		check("unmapped write", 32'(r), 32'(RESP_ERR));
		$display("test registers done");
		// Rollover in 16 and 13 bit widths from one step below the top, then 16 bit from ff1f with no rollover
		wr(OFF_IRQ_MASK, 32'h1);
		for (i = 0; i < 3; i++) begin
			wr(OFF_CTRL, 32'h0);
			wr(OFF_CL0, 32'(lows[i]));
			wr(OFF_CH0, 32'hff);
			wr(OFF_MODE, mods[i]);
			wr(OFF_CTRL, 32'h10);
			repeat (40) @(posedge mclk);
			rd(OFF_CTRL, ctls[i], "overflow flag");
		end
		check("irq raised", 32'(irq), 32'h1);
		wr(OFF_CTRL, 32'h30);
		wr(OFF_ACK, 32'h1);
		rd(OFF_CTRL, 32'h10, "ack clear");
		wr(OFF_IRQ_ST, 32'h1);
		repeat (3) @(posedge mclk);
		check("irq cleared", 32'(irq), 32'h0);
		$display("test rollover done");
		// Auto-reload with a random reload byte, then timer 1 parked
		k = 8'($random(seed)) & 8'h7f;
		wr(OFF_CTRL, 32'h0);
		wr(OFF_CH1, 32'(k));
		wr(OFF_CL1, 32'hfe);
		wr(OFF_MODE, 32'h20);
		t0 = ticks;
		wr(OFF_CTRL, 32'h40);
		repeat (60) @(posedge mclk);
		rd(OFF_CTRL, 32'hc0, "reload overflow");
		wr(OFF_CTRL, 32'h0);
		rd(OFF_CH1, 32'(k), "reload source");
		axr(OFF_CL1, lv, r);
		check("reload window", 32'((lv[7:0] - k) inside {[3:6]}), 32'h1);
		check("baud ticks", 32'(ticks - t0), 32'h1);
		wr(OFF_CH0, 32'h0);
		wr(OFF_MODE, 32'h33);
		wr(OFF_CTRL, 32'h40);
		repeat (40) @(posedge mclk);
		rd(OFF_CL1, lv, "mode 3 hold");
		axr(OFF_CH0, v, r);
		check("split high byte", 32'(v[7:0] inside {[3:4]}), 32'h1);
		$display("test reload done");
		// Counter function gated by the interrupt pin
		wr(OFF_CTRL, 32'h0);
		wr(OFF_CL0, 32'h0);
		wr(OFF_CH0, 32'h0);
		wr(OFF_MODE, 32'h0d);
		wr(OFF_CTRL, 32'h10);
		f0 = falls;
		pulse_en <= 1'b1;
		repeat (288) @(posedge mclk);
		pulse_en <= 1'b0;
		repeat (80) @(posedge mclk);
		cnt = falls - f0;
		rd(OFF_CL0, 32'(cnt), "counted falls");
		gin <= 1'b0;
		pulse_en <= 1'b1;
		repeat (288) @(posedge mclk);
		pulse_en <= 1'b0;
		repeat (80) @(posedge mclk);
		rd(OFF_CL0, 32'(cnt), "gated off");
		$display("test counter done");
		// Level flags follow the low pin, then edge mode catches one fall
		rd(OFF_CTRL, 32'h1a, "level flags");
		gin <= 1'b1;
		repeat (4) @(posedge mclk);
		wr(OFF_CTRL, 32'h05);
		rd(OFF_CTRL, 32'h05, "edge armed");
		gin <= 1'b0;
		repeat (4) @(posedge mclk);
		rd(OFF_CTRL, 32'h0f, "edge caught");
		$display("test flags done");
		tally_and_finish();
	end
endmodule
